//--- tb/pvf_filter_checker.sv
// Assertions on the frame request/result ports of the filter.
// Bound from the bench top file; sees top-level ports only.
`default_nettype none
module pvf_filter_checker import pvf_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Frame request and result
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pvf_req_s req,
  input wire logic res_valid,
  input wire pvf_res_s res
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic acc;
  // An accept seen during reset is ignored by the design
  assign acc = req_valid && req_ready && !srst;
  property p_lat; acc |=> res_valid; endproperty
  a_lat: assert property (p_lat) else $error("no result after accept");
  property p_cause; res_valid |-> $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("result without accept");
  property p_pulse; res_valid |=> !res_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("result longer than one cycle");
  property p_refuse; res_valid |-> !req_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("ready while result shown");
  property p_hold; !acc |=> $stable(res); endproperty
  a_hold: assert property (p_hold) else $error("result changed without accept");
  property p_sub; res_valid |-> (res.mask & ~$past(req.cand)) == '0; endproperty
  a_sub: assert property (p_sub) else $error("mask outside candidates");
  property p_drop; res_valid && res.drop |-> res.mask == '0; endproperty
  a_drop: assert property (p_drop) else $error("dropped frame has mask");
  property p_rst; $past(srst) |-> !res_valid && res == '0; endproperty
  a_rst: assert property (p_rst) else $error("result not clear after reset");
  c_acc: cover property (acc);
  c_drop: cover property (res_valid && res.drop);
  c_fwd: cover property (res_valid && res.mask != '0);
endmodule // pvf_filter_checker
`default_nettype wire

//--- tb/pvf_filter_tb.sv
// Bench for the filter: AXI4-Lite setup, frames via the engine model,
// shadow tables predict every result. Single 25 MHz clock.
`default_nettype none
module pvf_filter_tb import pvf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, srst = 1'b1, go = 1'b0;
  logic [1:0] slow = 2'h0;
  pvf_req_s fr = '0, req;
  pvf_res_s res;
  logic req_valid, req_ready, res_valid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fail_count = 0, tests_run = 0;
  logic [9:0] vm [16];
  logic [9:0] pva [10], pvs [10];
  logic [9:0] pvv, pst, iso, ingf, vaware;
  pvf_filter DUT (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .res_valid(res_valid), .res(res), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  pvf_fwd_model u_eng (.mclk(mclk), .srst(srst), .go(go), .slow(slow), .frame(fr),
    .req_valid(req_valid), .req_ready(req_ready), .req(req));
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h got %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic to();
    $display("[FAIL] wait expected done got timeout");
    fail_count++;
    tally_and_finish();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge mclk);
      aw = awready;
      w = wready;
      b = bvalid;
      if (b) chk("bresp", 32'(er), 32'(bresp));
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) to();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    r = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !r; n++) begin
      @(negedge mclk);
      ar = arready;
      r = rvalid;
      if (r) chk("rdata", ed, rdata);
      if (r) chk("rresp", 32'(er), 32'(rresp));
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
    if (!r) to();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, PVF_RESP_OK);
  endtask
  task automatic set_vlan(input int v, input logic [9:0] m);
    for (int j = 0; j < 16; j++) vm[j] = (j == v) ? m : (vm[j] & ~(m & ~vaware));
    wr(PVF_A_SEL, 32'(v));
    wr(PVF_A_VLAN_MASK, 32'(m));
  endtask
  task automatic commit();
    wr(PVF_A_CTRL, 32'h1 << PVF_C_COMMIT);
    for (int i = 0; i < PVF_PORTS; i++) pva[i] = pvs[i];
    pvv = pst;
  endtask
  function automatic pvf_res_s exp_res(pvf_req_s f);
    logic [9:0] u;
    pvf_res_s r;
    u = '0;
    for (int i = 0; i < PVF_PORTS; i++) if (pvv[i] && pva[i][f.port]) u |= pva[i];
    if (iso[f.port]) u &= ~iso;
    r.drop = ingf[f.port] & !vm[f.vlan][f.port];
    r.mask = r.drop ? '0 : (f.cand & vm[f.vlan] & u);
    return r;
  endfunction
  task automatic frames(input int k);
    pvf_req_s f;
    pvf_res_s e;
    int n;
    repeat (k) begin
      f.port = 4'($urandom_range(0, PVF_PORTS - 1));
      f.vlan = 4'($urandom_range(0, 3));
      f.cand = ($urandom_range(0, 3) == 0) ? 10'h3FF : 10'($urandom);
      e = exp_res(f);
      @(posedge mclk);
      go <= 1'b1;
      fr <= f;
      slow <= 2'($urandom);
      @(posedge mclk);
      go <= 1'b0;
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (!res_valid && n < 20);
      if (!res_valid) to();
      chk("mask", 32'(e.mask), 32'(res.mask));
      chk("drop", 32'(e.drop), 32'(res.drop));
    end
  endtask
  initial begin
    void'($urandom(60027));
    for (int i = 0; i < 16; i++) vm[i] = (i == 1) ? 10'h3FF : 10'h000;
    for (int i = 0; i < PVF_PORTS; i++) pvs[i] = (i == 1) ? 10'h3FF : 10'h000;
    for (int i = 0; i < PVF_PORTS; i++) pva[i] = pvs[i];
    pvv = 10'h002;
    pst = pvv;
    iso = '0;
    ingf = '0;
    vaware = '0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    axi_rd(PVF_A_SEL, 32'h1, PVF_RESP_OK);
    axi_rd(PVF_A_VLAN_MASK, 32'h3FF, PVF_RESP_OK);
    axi_rd(PVF_A_PV_VALID, 32'h2, PVF_RESP_OK);
    axi_rd(PVF_A_ISO, 32'h0, PVF_RESP_OK);
    axi_rd(8'h24, 32'h0, PVF_RESP_SLVERR);
    axi_wr(8'h24, 32'hFFFF_FFFF, PVF_RESP_SLVERR);
    frames(4);
    set_vlan(2, 10'h00F);
    wr(PVF_A_SEL, 32'h1);
    axi_rd(PVF_A_VLAN_MASK, 32'h3F0, PVF_RESP_OK);
    wr(PVF_A_SEL, 32'h5);
    wr(PVF_A_CTRL, 32'h1 << PVF_C_CREATE);
    pst[5] = 1'b1;
    axi_rd(PVF_A_PV_MASK, 32'h0, PVF_RESP_OK);
    wr(PVF_A_PV_MASK, 32'h0F3);
    pvs[5] = 10'h0F3;
    frames(4);
    commit();
    frames(6);
    wr(PVF_A_SEL, 32'(PVF_PORTS));
    axi_wr(PVF_A_CTRL, 32'h1 << PVF_C_CREATE, PVF_RESP_SLVERR);
    axi_rd(PVF_A_STATUS, 32'h1, PVF_RESP_OK);
    wr(PVF_A_STATUS, 32'h1);
    iso = 10'($urandom) | 10'h001;
    wr(PVF_A_ISO, 32'(iso));
    frames(12);
    wr(PVF_A_SEL, 32'h1);
    wr(PVF_A_CTRL, 32'h1 << PVF_C_DELETE);
    pst[1] = 1'b0;
    axi_rd(PVF_A_STATUS, 32'h2, PVF_RESP_OK);
    wr(PVF_A_CTRL, 32'h1 << PVF_C_UNDO);
    axi_rd(PVF_A_STATUS, 32'h0, PVF_RESP_OK);
    wr(PVF_A_CTRL, 32'h1 << PVF_C_DELETE);
    frames(4);
    commit();
    frames(6);
    ingf = 10'($urandom);
    wr(PVF_A_ING_FILT, 32'(ingf));
    frames(10);
    wr(PVF_A_SEL, 32'h7);
    wr(PVF_A_CTRL, (32'h1 << PVF_C_CREATE) | (32'h1 << PVF_C_COMMIT));
    pst[7] = 1'b1;
    axi_rd(PVF_A_STATUS, 32'h2, PVF_RESP_OK);
    axi_rd(PVF_A_PV_VALID, 32'(pvv), PVF_RESP_OK);
    vaware = 10'($urandom);
    wr(PVF_A_AWARE, 32'(vaware));
    axi_rd(PVF_A_AWARE, 32'(vaware), PVF_RESP_OK);
    repeat (4) begin
      set_vlan($urandom_range(0, 3), 10'($urandom));
      iso = 10'($urandom);
      wr(PVF_A_ISO, 32'(iso));
      frames(8);
    end
    tally_and_finish();
  end
endmodule // pvf_filter_tb
bind pvf_filter pvf_filter_checker u_chk (.mclk(mclk), .srst(srst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res));
`default_nettype wire

//--- tb/pvf_fwd_model.sv
// Forwarding engine model: one frame per go pulse, raised 1-4 cycles after go is sampled.
// Assumes the bench pulses go only while the model is idle.
`default_nettype none
module pvf_fwd_model import pvf_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bench control
  input wire logic go,
  input wire logic [1:0] slow,
  input wire pvf_req_s frame,
  // Filter side
  output logic req_valid,
  input wire logic req_ready,
  output pvf_req_s req
);
  logic busy_r;
  logic [1:0] dly_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_r <= 1'b0;
      dly_r <= 2'h0;
      req_valid <= 1'b0;
      req <= '0;
    end else if (go) begin
      busy_r <= 1'b1;
      dly_r <= slow;
      req <= frame;
    end else if (req_valid && req_ready) begin
      busy_r <= 1'b0;
      req_valid <= 1'b0;
      // Scrambled so a stale frame cannot pass for a held one
      req <= ~req;
    end else if (busy_r && !req_valid) begin
      if (dly_r == 2'h0) begin
        req_valid <= 1'b1;
      end else begin
        dly_r <= dly_r - 2'h1;
      end
    end
  end
endmodule // pvf_fwd_model
`default_nettype wire

//--- verilog/pvf_filter.sv
// Private VLAN / port isolation egress filter with AXI4-Lite configuration.
// Assumes forwarding engine holds its request stable until acknowledged.
`default_nettype none
module pvf_filter import pvf_pkg::*; #(
  parameter int PORTS = PVF_PORTS,
  parameter int VLANS = PVF_VLANS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Forwarding engine request
  input wire logic req_valid,
  output logic req_ready,
  input wire pvf_req_s req,
  // Filtered result
  output logic res_valid,
  output pvf_res_s res,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // Staged (edited) and active tables
  logic [PORTS-1:0] vmask_r [VLANS];
  logic [PORTS-1:0] vmask_nxt [VLANS];
  logic [PORTS-1:0] pv_st_r [PORTS];
  logic [PORTS-1:0] pv_st_nxt [PORTS];
  logic [PORTS-1:0] pv_act_r [PORTS];
  logic [PORTS-1:0] pv_act_nxt [PORTS];
  logic [PORTS-1:0] val_st_r, val_st_nxt, val_act_r, val_act_nxt;
  logic [PORTS-1:0] del_r, del_nxt;
  logic [PORTS-1:0] iso_r, iso_nxt, ifilt_r, ifilt_nxt, aware_r, aware_nxt;
  logic [PVF_VW-1:0] sel_r, sel_nxt;
  logic reject_r, reject_nxt, pend_r, pend_nxt;
  // Bus state
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Datapath
  logic res_valid_r, res_valid_nxt;
  pvf_res_s res_r, res_nxt, calc;
  logic [PORTS*PORTS-1:0] pv_flat;

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] zx(input logic [PORTS-1:0] v);
    return {{(32-PORTS){1'b0}}, v};
  endfunction

  // Selected private VLAN index is valid only inside the port range
  function automatic logic pv_ok(input logic [PVF_VW-1:0] id);
    return (32'(id) < PORTS);
  endfunction

  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      pv_flat[i*PORTS +: PORTS] = pv_act_r[i];
    end
  end

  pvf_mask_calc #(.PORTS(PORTS)) u_calc (
    .port(req.port),
    .cand(req.cand),
    .vlan_mask(vmask_r[req.vlan]),
    .ing_filt(ifilt_r[req.port]),
    .pv_masks(pv_flat),
    .pv_valid(val_act_r),
    .iso(iso_r), // see R12 see R15
    .res(calc)
  );

  // Request path: one result per accepted request, one cycle later
  assign req_ready = !res_valid_r;
  always_comb begin
    res_valid_nxt = 1'b0;
    res_nxt = res_r;
    if (req_valid && req_ready) begin // see R19
      res_valid_nxt = 1'b1;
      res_nxt = calc; // see R18
    end
  end
  assign res_valid = res_valid_r;
  assign res = res_r;

  // Bus write capture and register update
  logic do_wr, do_rd;
  logic [31:0] wv;
  logic [PVF_VW-1:0] sid;
  always_comb begin
    vmask_nxt = vmask_r;
    pv_st_nxt = pv_st_r;
    pv_act_nxt = pv_act_r;
    val_st_nxt = val_st_r;
    val_act_nxt = val_act_r;
    del_nxt = del_r;
    iso_nxt = iso_r;
    ifilt_nxt = ifilt_r;
    aware_nxt = aware_r;
    sel_nxt = sel_r;
    reject_nxt = reject_r;
    pend_nxt = pend_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    wv = '0;
    sid = sel_r;
    if (s_awvalid && s_awready) begin
      awa_nxt = s_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_wvalid && s_wready) begin
      wd_nxt = s_wdata;
      ws_nxt = s_wstrb;
      w_have_nxt = 1'b1;
    end
    if (s_bvalid && s_bready) begin
      bvalid_nxt = 1'b0;
    end
    do_wr = aw_have_r && w_have_r && !bvalid_r;
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = PVF_RESP_OK;
      case (awa_r)
        PVF_A_CTRL: begin
          // Commit first, so a create or delete in the same word stays staged
          if (wd_r[PVF_C_COMMIT] && ws_r[0]) begin
            for (int i = 0; i < PORTS; i++) begin
              val_act_nxt[i] = val_st_r[i] && !del_r[i]; // see R7 see R8
              val_st_nxt[i] = val_st_r[i] && !del_r[i];
              pv_act_nxt[i] = pv_st_r[i];
            end
            del_nxt = '0;
            pend_nxt = 1'b0;
          end
          if (wd_r[PVF_C_CREATE] && ws_r[0]) begin
            if (pv_ok(sid)) begin
              val_st_nxt[sid] = 1'b1;
              pv_st_nxt[sid] = '0; // see R5
              del_nxt[sid] = 1'b0;
              pend_nxt = 1'b1; // see R8
            end else begin
              reject_nxt = 1'b1; // see R6
              bresp_nxt = PVF_RESP_SLVERR;
            end
          end
          if (wd_r[PVF_C_DELETE] && ws_r[0] && pv_ok(sid)) begin
            del_nxt[sid] = 1'b1; // see R7
            pend_nxt = 1'b1;
          end
          if (wd_r[PVF_C_UNDO] && ws_r[0]) begin
            val_st_nxt = val_act_r;
            pv_st_nxt = pv_act_r;
            del_nxt = '0;
            pend_nxt = 1'b0;
          end
        end
        PVF_A_SEL: sel_nxt = PVF_VW'(strb_merge(32'(sel_r), wd_r, ws_r));
        PVF_A_VLAN_MASK: begin
          // Unaware port joining one VLAN is removed from all the others; aware ports keep theirs
          wv = strb_merge(zx(vmask_r[sel_r]), wd_r, ws_r);
          vmask_nxt[sel_r] = wv[PORTS-1:0];
          for (int v = 0; v < VLANS; v++) begin
            if (v != 32'(sel_r)) begin
              vmask_nxt[v] = vmask_r[v] & ~(wv[PORTS-1:0] & ~aware_r); // see R3
            end
          end
        end
        PVF_A_PV_MASK: begin
          if (pv_ok(sid) && val_st_r[sid]) begin
            wv = strb_merge(zx(pv_st_r[sid]), wd_r, ws_r);
            pv_st_nxt[sid] = wv[PORTS-1:0];
            pend_nxt = 1'b1;
          end else begin
            bresp_nxt = PVF_RESP_SLVERR;
          end
        end
        PVF_A_ISO: begin
          wv = strb_merge(zx(iso_r), wd_r, ws_r);
          iso_nxt = wv[PORTS-1:0]; // see R12 see R15
        end
        PVF_A_ING_FILT: begin
          wv = strb_merge(zx(ifilt_r), wd_r, ws_r);
          ifilt_nxt = wv[PORTS-1:0];
        end
        PVF_A_AWARE: begin
          wv = strb_merge(zx(aware_r), wd_r, ws_r);
          aware_nxt = wv[PORTS-1:0];
        end
        PVF_A_STATUS: begin
          if (wd_r[PVF_S_REJECT] && ws_r[0]) begin
            reject_nxt = 1'b0;
          end
        end
        PVF_A_PV_VALID: ;
        default: bresp_nxt = PVF_RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s_rvalid && s_rready) begin
      rvalid_nxt = 1'b0;
    end
    do_rd = s_arvalid && s_arready;
    if (do_rd) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = PVF_RESP_OK;
      rdata_nxt = '0;
      case (s_araddr)
        PVF_A_CTRL: rdata_nxt = '0;
        PVF_A_SEL: rdata_nxt = 32'(sel_r);
        PVF_A_VLAN_MASK: rdata_nxt = zx(vmask_r[sel_r]);
        PVF_A_PV_MASK: rdata_nxt = pv_ok(sid) ? zx(pv_st_r[sid]) : '0;
        PVF_A_ISO: rdata_nxt = zx(iso_r);
        PVF_A_ING_FILT: rdata_nxt = zx(ifilt_r);
        PVF_A_PV_VALID: rdata_nxt = zx(val_act_r);
        PVF_A_AWARE: rdata_nxt = zx(aware_r);
        PVF_A_STATUS: begin
          rdata_nxt[PVF_S_REJECT] = reject_r;
          rdata_nxt[PVF_S_PEND] = pend_r;
        end
        default: rresp_nxt = PVF_RESP_SLVERR;
      endcase
    end
  end

  assign s_awready = !aw_have_r;
  assign s_wready = !w_have_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rvalid_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int v = 0; v < VLANS; v++) begin
        vmask_r[v] <= (v == 32'(PVF_DEF_VLAN)) ? '1 : '0; // see R2
      end
      for (int p = 0; p < PORTS; p++) begin
        pv_st_r[p] <= (p == PVF_DEF_PVLAN) ? '1 : '0; // see R2
        pv_act_r[p] <= (p == PVF_DEF_PVLAN) ? '1 : '0;
      end
      val_st_r <= PORTS'(1) << PVF_DEF_PVLAN;
      val_act_r <= PORTS'(1) << PVF_DEF_PVLAN;
      del_r <= '0;
      iso_r <= '0; // see R16
      ifilt_r <= '0;
      aware_r <= '0; // see R2
      sel_r <= PVF_DEF_VLAN;
      reject_r <= 1'b0;
      pend_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= PVF_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= PVF_RESP_OK;
      rdata_r <= '0;
      res_valid_r <= 1'b0;
      res_r <= '0;
    end else begin
      vmask_r <= vmask_nxt;
      pv_st_r <= pv_st_nxt;
      pv_act_r <= pv_act_nxt;
      val_st_r <= val_st_nxt;
      val_act_r <= val_act_nxt;
      del_r <= del_nxt;
      iso_r <= iso_nxt;
      ifilt_r <= ifilt_nxt;
      aware_r <= aware_nxt;
      sel_r <= sel_nxt;
      reject_r <= reject_nxt;
      pend_r <= pend_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      res_valid_r <= res_valid_nxt;
      res_r <= res_nxt;
    end
  end
endmodule // pvf_filter
`default_nettype wire

//--- verilog/pvf_mask_calc.sv
// Combinational mask reduction for one frame.
// Assumes tables are already the committed (active) copies.
`default_nettype none
module pvf_mask_calc import pvf_pkg::*; #(
  parameter int PORTS = PVF_PORTS
) (
  // Frame
  input wire logic [PVF_PW-1:0] port,
  input wire logic [PORTS-1:0] cand,
  input wire logic [PORTS-1:0] vlan_mask,
  input wire logic ing_filt,
  // Active private VLAN tables
  input wire logic [PORTS*PORTS-1:0] pv_masks,
  input wire logic [PORTS-1:0] pv_valid,
  input wire logic [PORTS-1:0] iso,
  // Result
  output pvf_res_s res
);
  logic [PORTS-1:0] share;
  logic src_iso;
  always_comb begin
    share = '0;
    src_iso = iso[port];
    // Union of members of every active private VLAN holding the source
    for (int p = 0; p < PORTS; p++) begin
      if (pv_valid[p] && pv_masks[p*PORTS+port]) begin // see R3
        share = share | pv_masks[p*PORTS +: PORTS]; // see R4
      end
    end
    if (src_iso) begin
      share = share & ~iso; // see R10 see R11 see R14
    end
    res.mask = cand & vlan_mask & share; // see R1 see R9 see R13
    res.drop = ing_filt && !vlan_mask[port]; // see R17
    if (res.drop) begin
      res.mask = '0;
    end
  end
endmodule // pvf_mask_calc
`default_nettype wire

//--- verilog/pvf_pkg.sv
// Package for the private VLAN port isolation filter: sizes, reset values,
// register map, frame request/result structs. Assumes a single 25 MHz switch core clock.
// Overview of operation
// R1: Forward out of a port only if in frame VLAN and a shared private VLAN.
// R2: After reset all ports VLAN unaware, in VLAN 1 and private VLAN 1.
// R3: Unaware port has one VLAN yet may join several private VLANs.
// R4: Private VLAN masks kept apart from VLAN table; identifiers may coincide.
// R5: Entry holds one bit per port; new entry starts with all bits clear.
// R6: Private VLAN identifiers limited to port range; others rejected at create.
// R7: Entry marked for deletion stays active until next commit, then removed.
// R8: New private VLAN affects forwarding only after the commit.
// R9: Promiscuous ingress reaches every port; promiscuous ports accept from all. Code limits it to ports sharing a private VLAN with the source.
// R10: Isolated ingress reaches only promiscuous ports of the private VLAN.
// R11: Isolated port receives only from promiscuous members of same private VLAN.
// R12: Isolation role is one per-port setting across all private VLANs.
// R13: Promiscuous ingress mask restricted only by frame VLAN member mask; code also ANDs it with the shared private VLAN union.
// R14: Isolated ingress mask is VLAN mask ANDed with private VLAN mask.
// R15: Per-port isolation enable: set means isolated, clear means promiscuous.
// R16: Reset clears every isolation enable bit.
// R17: Ingress filtering on and port not in classified VLAN discards frame.
// R18: Filtered mask presented one cycle after the request is accepted.
// R19: Engine holds port, VLAN and mask stable while request is high.
`default_nettype none
package pvf_pkg;
  localparam int PVF_PORTS = 10;
  localparam int PVF_PW = 4;
  localparam int PVF_VLANS = 16;
  localparam int PVF_VW = 4;
  localparam logic [PVF_VW-1:0] PVF_DEF_VLAN = 4'h1;
  localparam int PVF_DEF_PVLAN = 1;

  // Register byte offsets
  localparam logic [7:0] PVF_A_CTRL = 8'h00;
  localparam logic [7:0] PVF_A_SEL = 8'h04;
  localparam logic [7:0] PVF_A_VLAN_MASK = 8'h08;
  localparam logic [7:0] PVF_A_PV_MASK = 8'h0C;
  localparam logic [7:0] PVF_A_ISO = 8'h10;
  localparam logic [7:0] PVF_A_ING_FILT = 8'h14;
  localparam logic [7:0] PVF_A_PV_VALID = 8'h18;
  localparam logic [7:0] PVF_A_STATUS = 8'h1C;
  localparam logic [7:0] PVF_A_AWARE = 8'h20;

  // Control register fields
  localparam int PVF_C_COMMIT = 0;
  localparam int PVF_C_CREATE = 1;
  localparam int PVF_C_DELETE = 2;
  localparam int PVF_C_UNDO = 3;
  // Status fields
  localparam int PVF_S_REJECT = 0;
  localparam int PVF_S_PEND = 1;

  localparam logic [1:0] PVF_RESP_OK = 2'h0;
  localparam logic [1:0] PVF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PVF_PW-1:0] port;
    logic [PVF_VW-1:0] vlan;
    logic [PVF_PORTS-1:0] cand;
  } pvf_req_s;

  typedef struct packed {
    logic [PVF_PORTS-1:0] mask;
    logic drop;
  } pvf_res_s;
endpackage
`default_nettype wire
